//--- ccrs_regs.sv
// Purpose: Control register file and command queue front end of a coprocessor element
// Assumes: Core and DMA engine run on clk; their signals are not resynchronised
// Notes: ce low freezes every flip-flop
//
// Summary of operation
// - Writing all ones to a class status clears it; masks then get OS values.
// - Both suspend fields written zero resumes command queue processing.
// - Command write yields an enqueue result; nonzero means reprogram and retry.
// - Group zero completion shows 01, or raises class two tag interrupt.
// - Supervisor waits for stop or interrupt, then clears handled bits by one.
`timescale 1ns/1ps
module ccrs_regs #(
  parameter int CHAN_N = ccrs_pkg::CHAN_N
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [ccrs_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Core run interface
  input wire logic core_running,
  input wire logic core_stop_event,
  input wire logic [15:0] core_stop_code,
  input wire logic core_error_event,
  output logic core_run_request,
  // DMA engine interface
  output logic dma_valid,
  output ccrs_pkg::ccrs_dma_cmd_t dma_cmd,
  input wire logic dma_ready,
  input wire logic dma_done,
  // Supervisor mailboxes to the core
  output logic [31:0] signal_notification_one,
  output logic [31:0] signal_notification_two,
  output logic [31:0] next_program_counter
);
  logic [31:0] chan_data [CHAN_N];
  logic [31:0] next_chan_data [CHAN_N];
  logic [ccrs_pkg::CNT_W-1:0] chan_count [CHAN_N];
  logic [ccrs_pkg::CNT_W-1:0] next_chan_count [CHAN_N];
  logic [ccrs_pkg::CHAN_W-1:0] channel_selector, next_channel_selector;
  logic [31:0] int_stat0, int_stat1, int_stat2, int_mask0, int_mask1, int_mask2;
  logic [31:0] next_int_stat0, next_int_stat1, next_int_stat2;
  logic [31:0] next_int_mask0, next_int_mask1, next_int_mask2;
  logic [31:0] transfer_class_quota, next_transfer_class_quota;
  logic [31:0] proxy_tag_query_mask, next_proxy_tag_query_mask;
  logic [31:0] next_sig1, next_sig2, next_npc, next_readdata;
  ccrs_pkg::ccrs_dma_cmd_t staged, next_staged, next_dma_cmd;
  ccrs_pkg::ccrs_dma_state_t dma_state, next_dma_state;
  logic [1:0] enqueue_result_code, proxy_tag_completion, query_kind_select, queue_status;
  logic [1:0] next_enqueue_result_code, next_proxy_tag_completion, next_query_kind_select;
  logic [15:0] stop_reason_code, next_stop_reason_code;
  logic suspend_control, suspend_mode, stopped, running_q;
  logic next_suspend_control, next_suspend_mode, next_stopped, next_running_q;
  logic next_dma_valid, next_core_run_request, next_waitrequest;
  logic wr_now, rd_take, queue_suspended, tag0_done;

  // Write commits at the edge where waitrequest is low; read data is prepared one edge earlier
  assign wr_now = write && !waitrequest;
  assign rd_take = read && waitrequest;
  assign queue_suspended = suspend_control || suspend_mode;
  assign queue_status = (queue_suspended && dma_state == ccrs_pkg::CCRS_IDLE) ?
                        ccrs_pkg::SS_SUSPENDED : ccrs_pkg::SS_RUNNING;
  assign tag0_done = dma_done && dma_state == ccrs_pkg::CCRS_WAIT && dma_cmd.tag == 8'h00;
  // Bus answer and read mux
  always_comb begin
    next_waitrequest = !((read || write) && waitrequest);
    next_readdata = readdata;
    if (rd_take) begin
      next_readdata = 32'h0000_0000;
      case (address)
        ccrs_pkg::OFF_CHAN_SEL: next_readdata = {27'h0, channel_selector};
        ccrs_pkg::OFF_CHAN_DATA: next_readdata = chan_data[channel_selector];
        ccrs_pkg::OFF_CHAN_CNT: next_readdata = {24'h0, chan_count[channel_selector]};
        ccrs_pkg::OFF_INT_STAT0: next_readdata = int_stat0;
        ccrs_pkg::OFF_INT_STAT1: next_readdata = int_stat1;
        ccrs_pkg::OFF_INT_STAT2: next_readdata = int_stat2;
        ccrs_pkg::OFF_INT_MASK0: next_readdata = int_mask0;
        ccrs_pkg::OFF_INT_MASK1: next_readdata = int_mask1;
        ccrs_pkg::OFF_INT_MASK2: next_readdata = int_mask2;
        ccrs_pkg::OFF_TCLASS: next_readdata = transfer_class_quota;
        ccrs_pkg::OFF_FC_CTRL: begin
          next_readdata[ccrs_pkg::FC_SC_BIT] = suspend_control;
          next_readdata[ccrs_pkg::FC_SM_BIT] = suspend_mode;
          next_readdata[ccrs_pkg::FC_SS_LSB +: 2] = queue_status;
        end
        ccrs_pkg::OFF_DMA_LSA: next_readdata = staged.local_addr;
        ccrs_pkg::OFF_DMA_EAH: next_readdata = staged.eff_high;
        ccrs_pkg::OFF_DMA_EAL: next_readdata = staged.eff_low;
        ccrs_pkg::OFF_DMA_SIZE: next_readdata = staged.size;
        ccrs_pkg::OFF_DMA_TAG: next_readdata = {24'h0, staged.tag};
        ccrs_pkg::OFF_DMA_CMD: next_readdata = {16'h0, staged.code};
        ccrs_pkg::OFF_DMA_RESULT: next_readdata = {30'h0, enqueue_result_code};
        ccrs_pkg::OFF_QUERY_MASK: next_readdata = proxy_tag_query_mask;
        ccrs_pkg::OFF_TAG_DONE: next_readdata = {30'h0, proxy_tag_completion};
        ccrs_pkg::OFF_QUERY_KIND: next_readdata = {30'h0, query_kind_select};
        ccrs_pkg::OFF_RUN_CTRL: next_readdata = {31'h0, core_run_request};
        ccrs_pkg::OFF_RUN_STAT: begin
          next_readdata[ccrs_pkg::ST_RUN_BIT] = running_q;
          next_readdata[ccrs_pkg::ST_STOP_BIT] = stopped;
          next_readdata[ccrs_pkg::ST_CODE_LSB +: 16] = stop_reason_code;
        end
        ccrs_pkg::OFF_NPC: next_readdata = next_program_counter;
        ccrs_pkg::OFF_SIG1: next_readdata = signal_notification_one;
        ccrs_pkg::OFF_SIG2: next_readdata = signal_notification_two;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end
  // Register writes, status events and the command queue
  always_comb begin
    next_chan_data = chan_data;
    next_chan_count = chan_count;
    next_channel_selector = channel_selector;
    next_int_mask0 = int_mask0;
    next_int_mask1 = int_mask1;
    next_int_mask2 = int_mask2;
    next_transfer_class_quota = transfer_class_quota;
    next_suspend_control = suspend_control;
    next_suspend_mode = suspend_mode;
    next_staged = staged;
    next_dma_cmd = dma_cmd;
    next_enqueue_result_code = enqueue_result_code;
    next_proxy_tag_query_mask = proxy_tag_query_mask;
    next_proxy_tag_completion = proxy_tag_completion;
    next_query_kind_select = query_kind_select;
    next_core_run_request = core_run_request;
    next_sig1 = signal_notification_one;
    next_sig2 = signal_notification_two;
    next_npc = next_program_counter;
    next_dma_state = dma_state;
    next_dma_valid = dma_valid;
    next_stopped = stopped;
    next_stop_reason_code = stop_reason_code;
    next_running_q = core_running;
    next_int_stat0 = int_stat0;
    next_int_stat1 = int_stat1;
    next_int_stat2 = int_stat2;
    // Write-one-to-clear; an all-ones write clears the whole class
    if (wr_now && address == ccrs_pkg::OFF_INT_STAT0) next_int_stat0 = int_stat0 & ~writedata;
    if (wr_now && address == ccrs_pkg::OFF_INT_STAT1) next_int_stat1 = int_stat1 & ~writedata;
    if (wr_now && address == ccrs_pkg::OFF_INT_STAT2) next_int_stat2 = int_stat2 & ~writedata;
    if (wr_now) begin
      case (address)
        ccrs_pkg::OFF_CHAN_SEL: next_channel_selector = writedata[ccrs_pkg::CHAN_W-1:0];
        ccrs_pkg::OFF_CHAN_DATA: next_chan_data[channel_selector] = writedata;
        ccrs_pkg::OFF_CHAN_CNT: next_chan_count[channel_selector] = writedata[ccrs_pkg::CNT_W-1:0];
        ccrs_pkg::OFF_INT_MASK0: next_int_mask0 = writedata;
        ccrs_pkg::OFF_INT_MASK1: next_int_mask1 = writedata;
        ccrs_pkg::OFF_INT_MASK2: next_int_mask2 = writedata;
        ccrs_pkg::OFF_TCLASS: next_transfer_class_quota = writedata;
        ccrs_pkg::OFF_FC_CTRL: begin
          next_suspend_control = writedata[ccrs_pkg::FC_SC_BIT];
          next_suspend_mode = writedata[ccrs_pkg::FC_SM_BIT];
        end
        ccrs_pkg::OFF_DMA_LSA: next_staged.local_addr = writedata;
        ccrs_pkg::OFF_DMA_EAH: next_staged.eff_high = writedata;
        ccrs_pkg::OFF_DMA_EAL: next_staged.eff_low = writedata;
        ccrs_pkg::OFF_DMA_SIZE: next_staged.size = writedata;
        ccrs_pkg::OFF_DMA_TAG: next_staged.tag = writedata[7:0];
        ccrs_pkg::OFF_DMA_CMD: begin
          next_staged.code = writedata[15:0];
          // Queue holds one command; a full or suspended queue refuses the enqueue
          if (dma_state == ccrs_pkg::CCRS_IDLE && !queue_suspended) begin
            next_enqueue_result_code = ccrs_pkg::RC_OK;
            next_dma_cmd = next_staged;
            next_dma_valid = 1'b1;
            next_dma_state = ccrs_pkg::CCRS_ISSUE;
            if (staged.tag == 8'h00) next_proxy_tag_completion = 2'h0;
          end else begin
            next_enqueue_result_code = ccrs_pkg::RC_BUSY;
          end
        end
        ccrs_pkg::OFF_QUERY_MASK: next_proxy_tag_query_mask = writedata;
        ccrs_pkg::OFF_QUERY_KIND: next_query_kind_select = writedata[1:0];
        ccrs_pkg::OFF_RUN_CTRL: begin
          next_core_run_request = (writedata[1:0] == ccrs_pkg::RUN_REQ);
          if (writedata[1:0] == ccrs_pkg::RUN_REQ) next_stopped = 1'b0;
        end
        ccrs_pkg::OFF_NPC: next_npc = writedata;
        ccrs_pkg::OFF_SIG1: next_sig1 = writedata;
        ccrs_pkg::OFF_SIG2: next_sig2 = writedata;
        default: next_channel_selector = channel_selector;
      endcase
    end
    // DMA engine handshake
    case (dma_state)
      ccrs_pkg::CCRS_IDLE: next_dma_state = next_dma_state;
      ccrs_pkg::CCRS_ISSUE: if (dma_ready) begin
        next_dma_valid = 1'b0;
        next_dma_state = ccrs_pkg::CCRS_WAIT;
      end
      ccrs_pkg::CCRS_WAIT: if (dma_done) next_dma_state = ccrs_pkg::CCRS_IDLE;
      default: begin
        next_dma_state = ccrs_pkg::CCRS_IDLE;
        next_dma_valid = 1'b0;
      end
    endcase
    // Event sets come last so they win over a same-cycle clear
    if (tag0_done && proxy_tag_query_mask[0]) begin
      next_proxy_tag_completion = ccrs_pkg::TAG_COMPLETE;
      if (query_kind_select == ccrs_pkg::QK_ANY) next_int_stat2[ccrs_pkg::I2_TAG_BIT] = 1'b1;
    end
    if (core_stop_event) begin
      next_stopped = 1'b1;
      next_stop_reason_code = core_stop_code;
      next_core_run_request = 1'b0;
      next_int_stat2[ccrs_pkg::I2_STOP_BIT] = 1'b1;
    end
    if (core_error_event) next_int_stat0[ccrs_pkg::I0_ERR_BIT] = 1'b1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chan_data <= '{default: 32'h0000_0000};
      chan_count <= '{default: 8'h00};
      channel_selector <= 5'h00;
      int_stat0 <= 32'h0000_0000;
      int_stat1 <= 32'h0000_0000;
      int_stat2 <= 32'h0000_0000;
      int_mask0 <= 32'h0000_0000;
      int_mask1 <= 32'h0000_0000;
      int_mask2 <= 32'h0000_0000;
      transfer_class_quota <= 32'h0000_0000;
      suspend_control <= ccrs_pkg::RST_SC;
      suspend_mode <= ccrs_pkg::RST_SM;
      staged <= '0;
      dma_cmd <= '0;
      enqueue_result_code <= ccrs_pkg::RC_OK;
      proxy_tag_query_mask <= 32'h0000_0000;
      proxy_tag_completion <= 2'h0;
      query_kind_select <= 2'h0;
      stopped <= 1'b0;
      stop_reason_code <= 16'h0000;
      running_q <= 1'b0;
      dma_state <= ccrs_pkg::CCRS_IDLE;
      dma_valid <= 1'b0;
      core_run_request <= 1'b0;
      signal_notification_one <= 32'h0000_0000;
      signal_notification_two <= 32'h0000_0000;
      next_program_counter <= 32'h0000_0000;
      readdata <= 32'h0000_0000;
      waitrequest <= 1'b1;
    end else if (ce) begin
      chan_data <= next_chan_data;
      chan_count <= next_chan_count;
      channel_selector <= next_channel_selector;
      int_stat0 <= next_int_stat0;
      int_stat1 <= next_int_stat1;
      int_stat2 <= next_int_stat2;
      int_mask0 <= next_int_mask0;
      int_mask1 <= next_int_mask1;
      int_mask2 <= next_int_mask2;
      transfer_class_quota <= next_transfer_class_quota;
      suspend_control <= next_suspend_control;
      suspend_mode <= next_suspend_mode;
      staged <= next_staged;
      dma_cmd <= next_dma_cmd;
      enqueue_result_code <= next_enqueue_result_code;
      proxy_tag_query_mask <= next_proxy_tag_query_mask;
      proxy_tag_completion <= next_proxy_tag_completion;
      query_kind_select <= next_query_kind_select;
      stopped <= next_stopped;
      stop_reason_code <= next_stop_reason_code;
      running_q <= next_running_q;
      dma_state <= next_dma_state;
      dma_valid <= next_dma_valid;
      core_run_request <= next_core_run_request;
      signal_notification_one <= next_sig1;
      signal_notification_two <= next_sig2;
      next_program_counter <= next_npc;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
    end
  end
endmodule : ccrs_regs

//--- ccrs_pkg.sv
// Purpose: Shared constants and types for the context restore register block
// Assumes: 32-bit Avalon-MM slave with byte addresses, one aligned word per register
// Notes: Fields sit in the low bits except queue status (bit 8) and stop code (bit 16); bits outside a field read as zero
package ccrs_pkg;
  localparam int ADDR_W = 8;
  localparam int CHAN_N = 32;
  localparam int CHAN_W = 5;
  localparam int CNT_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CHAN_SEL = 8'h00;
  localparam logic [7:0] OFF_CHAN_DATA = 8'h04;
  localparam logic [7:0] OFF_CHAN_CNT = 8'h08;
  localparam logic [7:0] OFF_INT_STAT0 = 8'h10;
  localparam logic [7:0] OFF_INT_STAT1 = 8'h14;
  localparam logic [7:0] OFF_INT_STAT2 = 8'h18;
  localparam logic [7:0] OFF_INT_MASK0 = 8'h1C;
  localparam logic [7:0] OFF_INT_MASK1 = 8'h20;
  localparam logic [7:0] OFF_INT_MASK2 = 8'h24;
  localparam logic [7:0] OFF_TCLASS = 8'h28;
  localparam logic [7:0] OFF_FC_CTRL = 8'h2C;
  localparam logic [7:0] OFF_DMA_LSA = 8'h30;
  localparam logic [7:0] OFF_DMA_EAH = 8'h34;
  localparam logic [7:0] OFF_DMA_EAL = 8'h38;
  localparam logic [7:0] OFF_DMA_SIZE = 8'h3C;
  localparam logic [7:0] OFF_DMA_TAG = 8'h40;
  localparam logic [7:0] OFF_DMA_CMD = 8'h44;
  localparam logic [7:0] OFF_DMA_RESULT = 8'h48;
  localparam logic [7:0] OFF_QUERY_MASK = 8'h4C;
  localparam logic [7:0] OFF_TAG_DONE = 8'h50;
  localparam logic [7:0] OFF_QUERY_KIND = 8'h54;
  localparam logic [7:0] OFF_RUN_CTRL = 8'h58;
  localparam logic [7:0] OFF_RUN_STAT = 8'h5C;
  localparam logic [7:0] OFF_NPC = 8'h60;
  localparam logic [7:0] OFF_SIG1 = 8'h64;
  localparam logic [7:0] OFF_SIG2 = 8'h68;

  // Field positions
  localparam int FC_SC_BIT = 0;
  localparam int FC_SM_BIT = 1;
  localparam int FC_SS_LSB = 8;
  localparam int ST_RUN_BIT = 0;
  localparam int ST_STOP_BIT = 1;
  localparam int ST_CODE_LSB = 16;
  localparam int I0_ERR_BIT = 0;
  localparam int I2_TAG_BIT = 0;
  localparam int I2_STOP_BIT = 1;

  // Codes and reset values
  localparam logic [1:0] RC_OK = 2'h0;
  localparam logic [1:0] RC_BUSY = 2'h1;
  localparam logic [1:0] TAG_COMPLETE = 2'h1;
  localparam logic [1:0] QK_ANY = 2'h1;
  localparam logic [1:0] RUN_REQ = 2'h1;
  localparam logic [1:0] SS_SUSPENDED = 2'h3;
  localparam logic [1:0] SS_RUNNING = 2'h0;
  localparam logic RST_SC = 1'b1;
  localparam logic RST_SM = 1'b0;

  typedef enum logic [2:0] {
    CCRS_IDLE = 3'b001,
    CCRS_ISSUE = 3'b010,
    CCRS_WAIT = 3'b100
  } ccrs_dma_state_t;

  typedef struct packed {
    logic [31:0] local_addr;
    logic [31:0] eff_high;
    logic [31:0] eff_low;
    logic [31:0] size;
    logic [7:0] tag;
    logic [15:0] code;
  } ccrs_dma_cmd_t;
endpackage : ccrs_pkg

//--- ccrs_properties.sv
// Purpose: Concurrent checks on the ports of the context restore register block
// Assumes: ce held high by the bench
// Notes: Tracks queue resume and engine busy from the bus and the DMA handshake
`timescale 1ns/1ps
module ccrs_properties #(parameter int CHAN_N = ccrs_pkg::CHAN_N) (
  // Clock, reset and register bus
  input wire logic clk,
  input wire logic rst,
  input wire logic [ccrs_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  // Core and DMA engine
  input wire logic core_stop_event,
  input wire logic core_run_request,
  input wire logic dma_valid,
  input wire ccrs_pkg::ccrs_dma_cmd_t dma_cmd,
  input wire logic dma_ready,
  input wire logic dma_done
);
  logic commit, resumed, busy;
  assign commit = write && !waitrequest;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resumed <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (commit && address == ccrs_pkg::OFF_FC_CTRL) resumed <= writedata[1:0] == 2'h0;
      busy <= dma_valid || (busy && !dma_done);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_bus_answer; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
  property p_bus_single; !waitrequest |=> waitrequest; endproperty
  a_bus_single: assert property (p_bus_single) else $error("answer held too long");
  property p_resume_issue; commit && address == ccrs_pkg::OFF_DMA_CMD && resumed && !busy
    |=> dma_valid; endproperty
  a_resume_issue: assert property (p_resume_issue) else $error("command not issued");
  property p_refuse; commit && address == ccrs_pkg::OFF_DMA_CMD && !resumed && !busy
    |=> !dma_valid; endproperty
  a_refuse: assert property (p_refuse) else $error("command issued while suspended");
  property p_dma_hold; dma_valid && !dma_ready |=> dma_valid && $stable(dma_cmd); endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("command changed before accept");
  property p_dma_drop; dma_valid && dma_ready |=> !dma_valid; endproperty
  a_dma_drop: assert property (p_dma_drop) else $error("command valid after accept");
  property p_issue_cause; $rose(dma_valid) |-> $past(commit) &&
    $past(address) == ccrs_pkg::OFF_DMA_CMD; endproperty
  a_issue_cause: assert property (p_issue_cause) else $error("command without write");
  property p_run_stop; core_stop_event |=> !core_run_request; endproperty
  a_run_stop: assert property (p_run_stop) else $error("run request kept after stop");
endmodule : ccrs_properties

//--- ccrs_far_model.sv
// Purpose: Far side model of the DMA engine and the core behind the register block
// Assumes: Bench sets ready lag, run length and stop code between operations
// Notes: Stop code lines churn every cycle outside a stop event
`timescale 1ns/1ps
module ccrs_far_model (
  // Clock, reset and bench controls
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] lag,
  input wire logic [7:0] run_len,
  input wire logic [15:0] code,
  // DMA engine and core
  input wire logic dma_valid,
  output logic dma_ready,
  output logic dma_done,
  input wire logic core_run_request,
  output logic core_running,
  output logic core_stop_event,
  output logic [15:0] core_stop_code
);
  logic [1:0] lag_cnt, done_sr;
  logic [7:0] run_cnt;
  logic [15:0] churn;
  assign core_stop_code = core_stop_event ? code : churn;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {dma_ready, dma_done, done_sr, lag_cnt} <= '0;
      {core_running, core_stop_event, run_cnt, churn} <= '0;
    end else begin
      churn <= churn + 16'h0001;
      dma_ready <= dma_valid && !dma_ready && lag_cnt == lag;
      lag_cnt <= (dma_valid && !dma_ready && lag_cnt != lag) ? lag_cnt + 2'h1 : 2'h0;
      done_sr <= {done_sr[0], dma_valid && dma_ready};
      dma_done <= done_sr[1];
      core_stop_event <= core_run_request && !core_stop_event && run_cnt == run_len;
      if (!core_run_request || core_stop_event) begin
        run_cnt <= 8'h00;
        core_running <= 1'b0;
      end else begin
        run_cnt <= run_cnt + 8'h01;
        core_running <= run_cnt >= 8'h02 && run_cnt != run_len;
      end
    end
  end
endmodule : ccrs_far_model

//--- coprocessor_context_restore_sequencer_test.sv
// Purpose: Self-checking bench for the context restore register block
// Assumes: ce held high; the far side model answers DMA and run requests
// Notes: Expected read values are queued by the driver and compared by a monitor
`timescale 1ns/1ps
module coprocessor_context_restore_sequencer_test;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, read = 1'b0, write = 1'b0, core_error_event = 1'b0;
  logic [7:0] address = 8'h00, run_len = 8'h05;
  logic [31:0] writedata = 32'h0, readdata, signal_notification_one, signal_notification_two;
  // Xorshift seed 1221
  logic [31:0] next_program_counter, seed = 32'h000004C5;
  logic [31:0] v [3];
  logic [1:0] lag = 2'h0;
  logic [15:0] code = 16'h0000, core_stop_code;
  logic waitrequest, core_running, core_stop_event, core_run_request, dma_valid, dma_ready;
  logic dma_done;
  logic [63:0] exp_rd;
  logic [63:0] rd_q[$];
  logic [7:0] chans [8] = '{8'h00, 8'h03, 8'h18, 8'h15, 8'h17, 8'h1C, 8'h1D, 8'h1E};
  logic [7:0] cnts [8] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h01, 8'h01, 8'h00, 8'h01};
  ccrs_pkg::ccrs_dma_cmd_t dma_cmd, exp_dma;
  ccrs_pkg::ccrs_dma_cmd_t dma_q[$];
  int errors = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  ccrs_regs DUT (.*);
  ccrs_far_model far (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(string name, logic [151:0] seen, logic [151:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    {write, read} <= 2'b00;
    address <= ~a;
    writedata <= ~d;
  endtask : bus
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m = 32'hFFFFFFFF);
    rd_q.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask : rd
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0 && rd_q.size() > 0) begin
      exp_rd = rd_q.pop_front();
      check($sformatf("reg_%h", address), readdata & exp_rd[63:32], exp_rd[31:0]);
    end
    if (dma_valid && dma_ready === 1'b1 && dma_q.size() > 0) begin
      check("dma_cmd", dma_cmd, dma_q.pop_front());
    end
  end
  task automatic end_of_test();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(ccrs_pkg::OFF_CHAN_SEL, {24'h0, chans[i]});
      wr(ccrs_pkg::OFF_CHAN_DATA, 32'h0);
      wr(ccrs_pkg::OFF_CHAN_CNT, {24'h0, cnts[i]});
      rd(ccrs_pkg::OFF_CHAN_CNT, {24'h0, cnts[i]});
    end
    core_error_event <= 1'b1;
    @(posedge clk);
    core_error_event <= 1'b0;
    rd(ccrs_pkg::OFF_INT_STAT0, 32'h1, 32'h1);
    for (int i = 0; i < 3; i++) begin
      v[i] = rnd();
      wr(ccrs_pkg::OFF_INT_STAT0 + 8'(4 * i), 32'hFFFFFFFF);
      rd(ccrs_pkg::OFF_INT_STAT0 + 8'(4 * i), 32'h0);
      wr(ccrs_pkg::OFF_INT_MASK0 + 8'(4 * i), v[i]);
      rd(ccrs_pkg::OFF_INT_MASK0 + 8'(4 * i), v[i]);
    end
    wr(ccrs_pkg::OFF_TCLASS, 32'h10000000);
    rd(ccrs_pkg::OFF_TCLASS, 32'h10000000);
    rd(ccrs_pkg::OFF_FC_CTRL, 32'h00000301, 32'h00000303);
    wr(ccrs_pkg::OFF_DMA_CMD, 32'h00000048);
    rd(ccrs_pkg::OFF_DMA_RESULT, {30'h0, ccrs_pkg::RC_BUSY}, 32'h3);
    wr(ccrs_pkg::OFF_FC_CTRL, 32'h0);
    rd(ccrs_pkg::OFF_FC_CTRL, 32'h0, 32'h00000303);
    wr(ccrs_pkg::OFF_QUERY_MASK, 32'h1);
    for (int i = 0; i < 2; i++) begin
      // First pass signals completion by interrupt, second by polling only
      wr(ccrs_pkg::OFF_QUERY_KIND, {30'h0, (i == 0) ? ccrs_pkg::QK_ANY : 2'h0});
      exp_dma = {rnd(), rnd(), rnd(), rnd(), 8'h00, 16'h0048};
      if (i == 1) begin
        exp_dma.local_addr = 32'h0;
        exp_dma.size = 32'h00004000;
        exp_dma.code = 16'h0040;
      end
      lag <= 2'(rnd());
      dma_q.push_back(exp_dma);
      wr(ccrs_pkg::OFF_DMA_LSA, exp_dma.local_addr);
      wr(ccrs_pkg::OFF_DMA_EAH, exp_dma.eff_high);
      wr(ccrs_pkg::OFF_DMA_EAL, exp_dma.eff_low);
      wr(ccrs_pkg::OFF_DMA_SIZE, exp_dma.size);
      wr(ccrs_pkg::OFF_DMA_TAG, 32'h0);
      wr(ccrs_pkg::OFF_DMA_CMD, {16'h0, exp_dma.code});
      rd(ccrs_pkg::OFF_DMA_RESULT, 32'h0, 32'h3);
      repeat (20) @(posedge clk);
      rd(ccrs_pkg::OFF_TAG_DONE, {30'h0, ccrs_pkg::TAG_COMPLETE}, 32'h3);
      rd(ccrs_pkg::OFF_INT_STAT2, {31'h0, (i == 0)}, 32'h1);
      wr(ccrs_pkg::OFF_INT_STAT2, 32'h1);
      rd(ccrs_pkg::OFF_INT_STAT2, 32'h0, 32'h1);
    end
    for (int i = 0; i < 3; i++) begin
      v[i] = rnd();
      wr(ccrs_pkg::OFF_NPC + 8'(4 * i), v[i]);
    end
    repeat (2) @(posedge clk);
    check("next_program_counter", next_program_counter, v[0]);
    check("signal_notification_one", signal_notification_one, v[1]);
    check("signal_notification_two", signal_notification_two, v[2]);
    code <= v[0][15:0];
    wr(ccrs_pkg::OFF_RUN_CTRL, {30'h0, ccrs_pkg::RUN_REQ});
    repeat (30) @(posedge clk);
    rd(ccrs_pkg::OFF_RUN_STAT, {v[0][15:0], 16'h0002});
    rd(ccrs_pkg::OFF_RUN_CTRL, 32'h0, 32'h1);
    rd(ccrs_pkg::OFF_INT_STAT2, 32'h2, 32'h2);
    run_len <= 8'hC8;
    wr(ccrs_pkg::OFF_RUN_CTRL, {30'h0, ccrs_pkg::RUN_REQ});
    repeat (6) @(posedge clk);
    rd(ccrs_pkg::OFF_RUN_STAT, 32'h1, 32'h3);
    wr(ccrs_pkg::OFF_RUN_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    rd(ccrs_pkg::OFF_RUN_STAT, 32'h0, 32'h1);
    // Let the monitor take the last answer before closing
    @(posedge clk);
    check("pending", 152'(rd_q.size() + dma_q.size()), 152'h0);
    end_of_test();
  end
endmodule : coprocessor_context_restore_sequencer_test
bind ccrs_regs ccrs_properties #(.CHAN_N(CHAN_N)) u_props (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .waitrequest(waitrequest), .core_stop_event(core_stop_event),
  .core_run_request(core_run_request), .dma_valid(dma_valid), .dma_cmd(dma_cmd),
  .dma_ready(dma_ready), .dma_done(dma_done)
);
